/* File: src/offload_pkg.sv */
// shared constants for the mac vlan, checksum and pause offload block
package offload_pkg;
    // untagged maximum frame length in bytes, and one vlan tag
    localparam logic [15:0] MAX_UNTAGGED_LEN = 16'h05ee;
    localparam logic [15:0] TAG_LEN = 16'h0004;
    // tag sits after destination and source address (6 + 6 bytes)
    localparam logic [7:0] TAG_INSERT_OFFSET = 8'h0c;
    // tag control field layout
    localparam int PRIO_MSB = 15;
    localparam int PRIO_LSB = 13;
    localparam int VID_MSB = 11;
    // checksum request bit positions
    localparam int CSUM_IP_BIT = 0;
    localparam int CSUM_TCP_BIT = 1;
    localparam int CSUM_UDP_BIT = 2;
    // pause timing: quantum is 512 bit times of 1 ns each
    localparam int QUANTUM_BITS = 512;
    localparam int BIT_TIME_NS = 1;
    localparam int CLK_PERIOD_NS = 100;
    localparam int QUANTUM_NS = QUANTUM_BITS * BIT_TIME_NS;
    // least time: rounded up to whole cycles
    localparam int QUANTUM_CYC = (QUANTUM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] QUANTUM_RELOAD = 3'(QUANTUM_CYC - 1);
    // reset values
    localparam logic [15:0] PAUSE_RST = 16'h0000;
    localparam logic [2:0] SUB_RST = 3'h0;
endpackage

/* File: src/mac_vlan_csum_pause_offload.sv */
// frame level vlan, checksum and pause offload decisions of the mac
`timescale 1ns/1ns
module mac_vlan_csum_pause_offload #(
    parameter int LEVEL_W = 16 // receive fifo level width
) (
    input wire logic clk_i, // 10 MHz mac clock
    input wire logic sys_rst_i, // synchronous reset, high
    input wire logic ce_i, // clock enable, freezes state low
    // configuration bits
    input wire logic auto_tag_enable_i, // apply default tag
    input wire logic auto_untag_enable_i, // strip received tags
    input wire logic [15:0] default_tag_value_i, // default tag
    input wire logic [2:0] rx_priority_threshold_i, // irq threshold
    input wire logic tag_id_exact_filter_i, // exact id filter on
    input wire logic tag_id_hash_filter_i, // hash id filter on
    input wire logic [11:0] tag_id_match_i, // exact id value
    input wire logic [63:0] tag_id_hash_table_i, // hash bitmap
    input wire logic v6_checksum_enable_i, // ipv6 offload on
    input wire logic [2:0] rx_csum_enable_i, // verify ip,tcp,udp
    input wire logic flow_enable_i, // obey pause frames
    input wire logic flow_symmetric_i, // also send pause frames
    input wire logic [LEVEL_W-1:0] pause_on_level_i, // on level
    input wire logic [LEVEL_W-1:0] pause_off_level_i, // off level
    input wire logic [LEVEL_W-1:0] rx_fifo_level_i, // occupancy
    // transmit frame request from dma
    input wire logic tx_req_i, // frame waiting to start
    input wire logic desc_tag_insert_req_i, // descriptor tag request
    input wire logic [15:0] desc_tag_i, // descriptor tag value
    input wire logic [2:0] tx_frame_control_word_i, // csum requests
    input wire logic tx_is_v4_i, // frame holds ipv4
    input wire logic tx_is_v6_i, // frame holds ipv6
    input wire logic tx_is_tcp_i, // frame holds tcp
    input wire logic tx_is_udp_i, // frame holds udp
    output logic tx_go_o, // start taken this cycle
    output logic tx_start_o, // registered start pulse
    output logic tx_tag_en_o, // insert a tag
    output logic [15:0] tx_tag_o, // tag to insert
    output logic [7:0] tx_tag_offset_o, // insert byte offset
    output logic tx_fcs_recalc_o, // fcs over tagged frame
    output logic [2:0] tx_csum_do_o, // insert ip,tcp,udp
    // received frame summary from the parser
    input wire logic rx_done_i, // frame end pulse
    input wire logic rx_tagged_i, // frame carries a tag
    input wire logic [15:0] rx_tag_i, // received tag
    input wire logic [15:0] rx_len_i, // frame length
    input wire logic rx_is_ctrl_i, // mac control frame
    input wire logic rx_is_pause_i, // valid pause frame
    input wire logic [15:0] rx_pause_quanta_i, // requested quanta
    input wire logic rx_is_v4_i, // holds ipv4
    input wire logic rx_is_v6_i, // holds ipv6
    input wire logic rx_is_tcp_i, // holds tcp
    input wire logic rx_is_udp_i, // holds udp
    output logic rx_valid_o, // decision pulse
    output logic rx_deliver_o, // pass to host
    output logic rx_strip_o, // remove tags
    output logic rx_len_err_o, // too long
    output logic [15:0] tag_control_field_o, // status tag
    output logic rx_status_tagged_o, // status tag valid
    output logic [2:0] rx_csum_chk_o, // verify ip,tcp,udp
    input wire logic irq_flags_ack_i, // clear priority flag
    output logic rx_priority_irq_flag_o, // sticky priority flag
    output logic paused_o, // pause in force
    output logic pause_send_o // request device pause frame
);
    // ****************************************************************
    // helpers
    // ****************************************************************
    // hash index folds the 12 bit id onto the 64 entry table
    function automatic logic [5:0] id_hash(input logic [11:0] id);
        id_hash = id[5:0] ^ id[11:6];
    endfunction

    // ipv4 header checksum only exists for v4; l4 needs eligible ip
    function automatic logic [2:0] csum_sel(input logic [2:0] req, input logic v4,
                                            input logic v6, input logic tcp,
                                            input logic udp);
        logic ip_ok;
        ip_ok = v4 | (v6 & v6_checksum_enable_i);
        csum_sel = {req[offload_pkg::CSUM_UDP_BIT] & udp & ip_ok,
                    req[offload_pkg::CSUM_TCP_BIT] & tcp & ip_ok,
                    req[offload_pkg::CSUM_IP_BIT] & v4};
    endfunction

    // ****************************************************************
    // pause timer
    // ****************************************************************
    logic [15:0] pause_q, pause_d;
    logic [2:0] sub_q, sub_d;
    logic pause_take;

    assign pause_take = rx_done_i & rx_is_pause_i & flow_enable_i;

    // timer counts quanta down in whole cycles
    always_comb begin
        pause_d = pause_q;
        sub_d = sub_q;
        if (pause_take) begin
            pause_d = rx_pause_quanta_i;
            sub_d = offload_pkg::QUANTUM_RELOAD;
        end else if (pause_q != 16'h0000) begin
            if (sub_q == 3'h0) begin
                pause_d = pause_q - 16'h0001;
                sub_d = offload_pkg::QUANTUM_RELOAD;
            end else begin
                sub_d = sub_q - 3'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pause_q <= offload_pkg::PAUSE_RST;
            sub_q <= offload_pkg::SUB_RST;
        end else if (ce_i) begin
            pause_q <= pause_d;
            sub_q <= sub_d;
        end
    end

    assign paused_o = pause_q != 16'h0000;

    // ****************************************************************
    // transmit path
    // ****************************************************************
    logic start_q, tag_en_q, tag_en_d;
    logic [15:0] tag_q, tag_d;
    logic [2:0] csum_q, csum_d;

    assign tx_go_o = tx_req_i & ce_i & ~paused_o;

    // tag source and checksum choice latched at start
    always_comb begin
        tag_en_d = tag_en_q;
        tag_d = tag_q;
        csum_d = csum_q;
        if (tx_go_o) begin
            tag_en_d = desc_tag_insert_req_i | auto_tag_enable_i;
            tag_d = desc_tag_insert_req_i ? desc_tag_i : default_tag_value_i;
            // cleared request bits are never inserted
            csum_d = csum_sel(tx_frame_control_word_i, tx_is_v4_i, tx_is_v6_i,
                              tx_is_tcp_i, tx_is_udp_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            start_q <= 1'b0;
            tag_en_q <= 1'b0;
            tag_q <= 16'h0000;
            csum_q <= 3'h0;
        end else if (ce_i) begin
            start_q <= tx_go_o;
            tag_en_q <= tag_en_d;
            tag_q <= tag_d;
            csum_q <= csum_d;
        end
    end

    assign tx_start_o = start_q;
    assign tx_tag_en_o = tag_en_q;
    assign tx_tag_o = tag_q;
    assign tx_csum_do_o = csum_q;
    // fixed offset after source address, fcs covers tag
    assign tx_tag_offset_o = offload_pkg::TAG_INSERT_OFFSET;
    assign tx_fcs_recalc_o = tag_en_q;

    // ****************************************************************
    // receive path
    // ****************************************************************
    logic rx_valid_q, deliver_q, deliver_d, strip_q, strip_d, len_err_q, len_err_d;
    logic tagged_q, tagged_d, prio_q, prio_d;
    logic [15:0] stag_q, stag_d;
    logic [2:0] chk_q, chk_d;
    logic id_sel, filt_on, prio_hit;
    logic [15:0] max_len;

    assign max_len = offload_pkg::MAX_UNTAGGED_LEN + (rx_tagged_i ? offload_pkg::TAG_LEN
                                                                  : 16'h0000);
    assign filt_on = tag_id_exact_filter_i | tag_id_hash_filter_i;
    assign id_sel = (tag_id_exact_filter_i
                     & (rx_tag_i[offload_pkg::VID_MSB:0] == tag_id_match_i))
                  | (tag_id_hash_filter_i
                     & tag_id_hash_table_i[id_hash(rx_tag_i[offload_pkg::VID_MSB:0])]);
    assign prio_hit = rx_done_i & rx_tagged_i
                    & (rx_tag_i[offload_pkg::PRIO_MSB:offload_pkg::PRIO_LSB]
                       >= rx_priority_threshold_i);

    // per frame decision and status
    always_comb begin
        deliver_d = deliver_q;
        strip_d = strip_q;
        len_err_d = len_err_q;
        tagged_d = tagged_q;
        stag_d = stag_q;
        chk_d = chk_q;
        // set wins over acknowledge
        prio_d = prio_hit | (prio_q & ~irq_flags_ack_i);
        if (rx_done_i) begin
            len_err_d = rx_len_i > max_len;
            deliver_d = ~len_err_d & (~filt_on | (rx_tagged_i & id_sel));
            strip_d = rx_tagged_i & auto_untag_enable_i;
            tagged_d = rx_tagged_i;
            stag_d = rx_tagged_i ? rx_tag_i : 16'h0000;
            chk_d = csum_sel(rx_csum_enable_i, rx_is_v4_i, rx_is_v6_i,
                             rx_is_tcp_i, rx_is_udp_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rx_valid_q <= 1'b0;
            deliver_q <= 1'b0;
            strip_q <= 1'b0;
            len_err_q <= 1'b0;
            tagged_q <= 1'b0;
            stag_q <= 16'h0000;
            chk_q <= 3'h0;
            prio_q <= 1'b0;
        end else if (ce_i) begin
            rx_valid_q <= rx_done_i;
            deliver_q <= deliver_d;
            strip_q <= strip_d;
            len_err_q <= len_err_d;
            tagged_q <= tagged_d;
            stag_q <= stag_d;
            chk_q <= chk_d;
            prio_q <= prio_d;
        end
    end

    assign rx_valid_o = rx_valid_q;
    assign rx_deliver_o = deliver_q;
    assign rx_strip_o = strip_q;
    assign rx_len_err_o = len_err_q;
    assign rx_status_tagged_o = tagged_q;
    assign tag_control_field_o = stag_q;
    assign rx_csum_chk_o = chk_q;
    assign rx_priority_irq_flag_o = prio_q;

    // ****************************************************************
    // automatic pause generation
    // ****************************************************************
    logic flow_q, flow_d, send_q, send_d;

    // hysteresis between on and off levels
    always_comb begin
        flow_d = flow_q;
        send_d = 1'b0;
        if (!flow_q && rx_fifo_level_i >= pause_on_level_i) begin
            flow_d = 1'b1;
            // pause on reaching the on level
            send_d = 1'b1;
        end else if (flow_q && rx_fifo_level_i <= pause_off_level_i) begin
            flow_d = 1'b0;
        end else if (flow_q && rx_done_i && !rx_is_ctrl_i) begin
            send_d = 1'b1;
        end
        // pause frames are only requested with flow control on and in symmetric mode
        send_d = send_d & flow_enable_i & flow_symmetric_i;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            flow_q <= 1'b0;
            send_q <= 1'b0;
        end else if (ce_i) begin
            flow_q <= flow_d;
            send_q <= send_d;
        end
    end

    assign pause_send_o = send_q;

    // ****************************************************************
    // assertions
    // ****************************************************************
    pause_blocks_tx_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        paused_o |-> !tx_go_o)
        else $error("transmit started while paused");
    pause_zero_ends_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && pause_take && rx_pause_quanta_i == 16'h0000) |=> !paused_o)
        else $error("zero pause did not end pause");
    pause_quantum_len_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && pause_take && rx_pause_quanta_i == 16'h0001) ##1 (ce_i && !pause_take) [*6]
        |=> !paused_o)
        else $error("one quantum lasted too long");
    tag_priority_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && tx_go_o && desc_tag_insert_req_i)
        |=> tx_tag_en_o && tx_tag_o == $past(desc_tag_i))
        else $error("descriptor tag not used");
    status_tag_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && rx_done_i && rx_tagged_i) |=> tag_control_field_o == $past(rx_tag_i))
        else $error("received tag not copied");
    untag_ctrl_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && rx_done_i) |=> rx_strip_o == $past(rx_tagged_i && auto_untag_enable_i))
        else $error("strip decision wrong");
    filter_drop_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && rx_done_i && filt_on && !rx_tagged_i) |=> !rx_deliver_o)
        else $error("untagged frame passed filter");
    prio_flag_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && prio_hit) |=> rx_priority_irq_flag_o)
        else $error("priority flag not set");
    v6_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && tx_go_o && !tx_is_v4_i && !v6_checksum_enable_i) |=> tx_csum_do_o == 3'h0)
        else $error("checksum on ineligible frame");
    asym_silent_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ($past(ce_i) && !$past(flow_symmetric_i)) |-> !pause_send_o)
        else $error("pause sent in asymmetric mode");
    pause_on_send_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && !flow_q && rx_fifo_level_i >= pause_on_level_i && flow_enable_i
         && flow_symmetric_i) |=> pause_send_o)
        else $error("no pause at on level");
endmodule

/* File: sim/link_partner_model.sv */
// link partner model: received frame summaries handed to the offload block
`timescale 1ns/1ns
module link_partner_model (
    input wire logic clk_i, // mac clock
    output logic rx_done_o, // frame end pulse
    output logic rx_tagged_o, // frame carries a tag
    output logic [15:0] rx_tag_o, // tag value
    output logic [15:0] rx_len_o, // frame length
    output logic rx_ctrl_o, // mac control frame
    output logic rx_pause_o, // pause frame
    output logic [15:0] rx_quanta_o, // pause quanta
    output logic [3:0] rx_l34_o // v4, v6, tcp, udp
);
    // ****
    // frame delivery
    // ****
    // quiet line at start
    initial begin
        rx_done_o = 1'b0;
        {rx_tagged_o, rx_tag_o, rx_len_o, rx_ctrl_o, rx_pause_o, rx_quanta_o, rx_l34_o} = '0;
    end
    // one frame summary of any kind, held for a single cycle
    // fields go stale-inverted after the pulse, so late sampling misreads
    task automatic send(input logic [54:0] f);
        @(posedge clk_i);
        rx_done_o <= 1'b1;
        {rx_tagged_o, rx_tag_o, rx_len_o, rx_ctrl_o, rx_pause_o, rx_quanta_o, rx_l34_o} <= f;
        @(posedge clk_i);
        rx_done_o <= 1'b0;
        {rx_tagged_o, rx_tag_o, rx_len_o, rx_ctrl_o, rx_pause_o, rx_quanta_o, rx_l34_o} <= ~f;
    endtask
endmodule

/* File: sim/mac_vlan_csum_pause_offload_bench.sv */
// self-checking bench for the vlan, checksum and pause offload block
`timescale 1ns/1ns
module mac_vlan_csum_pause_offload_bench;
    logic clk_i, sys_rst_i, ce_i, auto_tag_enable_i, auto_untag_enable_i, v6_checksum_enable_i;
    logic tag_id_exact_filter_i, tag_id_hash_filter_i, flow_enable_i, flow_symmetric_i;
    logic tx_req_i, desc_tag_insert_req_i, irq_flags_ack_i, rx_done_i, rx_tagged_i, rx_is_ctrl_i;
    logic rx_is_pause_i, tx_go_o, tx_start_o, tx_tag_en_o, tx_fcs_recalc_o, rx_valid_o;
    logic rx_deliver_o, rx_strip_o, rx_len_err_o, rx_status_tagged_o, rx_priority_irq_flag_o;
    logic paused_o, pause_send_o;
    logic [2:0] rx_priority_threshold_i, rx_csum_enable_i, tx_frame_control_word_i;
    logic [2:0] tx_csum_do_o, rx_csum_chk_o;
    logic [3:0] tx_l34, rx_l34;
    logic [7:0] tx_tag_offset_o;
    logic [11:0] tag_id_match_i;
    logic [15:0] default_tag_value_i, desc_tag_i, pause_on_level_i, pause_off_level_i;
    logic [15:0] rx_fifo_level_i, rx_tag_i, rx_len_i, rx_pause_quanta_i, tx_tag_o;
    logic [15:0] tag_control_field_o;
    logic [63:0] tag_id_hash_table_i;
    int bad_count = 0;
    int n_compared = 0;

    mac_vlan_csum_pause_offload DUT (
        .clk_i, .sys_rst_i, .ce_i, .auto_tag_enable_i, .auto_untag_enable_i,
        .default_tag_value_i, .rx_priority_threshold_i, .tag_id_exact_filter_i,
        .tag_id_hash_filter_i, .tag_id_match_i, .tag_id_hash_table_i, .v6_checksum_enable_i,
        .rx_csum_enable_i, .flow_enable_i, .flow_symmetric_i, .pause_on_level_i,
        .pause_off_level_i, .rx_fifo_level_i, .tx_req_i, .desc_tag_insert_req_i, .desc_tag_i,
        .tx_frame_control_word_i, .tx_is_v4_i(tx_l34[3]), .tx_is_v6_i(tx_l34[2]),
        .tx_is_tcp_i(tx_l34[1]), .tx_is_udp_i(tx_l34[0]), .tx_go_o, .tx_start_o, .tx_tag_en_o,
        .tx_tag_o, .tx_tag_offset_o, .tx_fcs_recalc_o, .tx_csum_do_o, .rx_done_i, .rx_tagged_i,
        .rx_tag_i, .rx_len_i, .rx_is_ctrl_i, .rx_is_pause_i, .rx_pause_quanta_i,
        .rx_is_v4_i(rx_l34[3]), .rx_is_v6_i(rx_l34[2]), .rx_is_tcp_i(rx_l34[1]),
        .rx_is_udp_i(rx_l34[0]), .rx_valid_o, .rx_deliver_o, .rx_strip_o, .rx_len_err_o,
        .tag_control_field_o, .rx_status_tagged_o, .rx_csum_chk_o, .irq_flags_ack_i,
        .rx_priority_irq_flag_o, .paused_o, .pause_send_o
    );
    link_partner_model lp (
        .clk_i, .rx_done_o(rx_done_i), .rx_tagged_o(rx_tagged_i), .rx_tag_o(rx_tag_i),
        .rx_len_o(rx_len_i), .rx_ctrl_o(rx_is_ctrl_i), .rx_pause_o(rx_is_pause_i),
        .rx_quanta_o(rx_pause_quanta_i), .rx_l34_o(rx_l34)
    );

    // ****
    // helpers
    // ****
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (bad_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // one transmit request, released right at the taking edge
    task automatic tx(input logic dreq, input logic [15:0] dtag, input logic aut,
                      input logic [2:0] req, input logic [3:0] l34);
        @(posedge clk_i);
        {tx_req_i, desc_tag_insert_req_i} <= {1'b1, dreq};
        {desc_tag_i, auto_tag_enable_i} <= {dtag, aut};
        {tx_frame_control_word_i, tx_l34} <= {req, l34};
        @(posedge clk_i);
        tx_req_i <= 1'b0;
        #1;
        check(tx_start_o, 1'b1);
    endtask
    task automatic rx(input logic tg, input logic [15:0] tag, input logic [15:0] len,
                      input logic ctl, input logic ps, input logic [15:0] q,
                      input logic [3:0] l34);
        lp.send({tg, tag, len, ctl, ps, q, l34});
        #1;
        check(rx_valid_o, 1'b1);
    endtask
    // pulses are one cycle wide, so sample once per cycle
    task automatic count_sends(input int n, output int c);
        c = 0;
        repeat (n) begin
            #1;
            if (pause_send_o === 1'b1) c++;
            @(posedge clk_i);
        end
    endtask

    // ****
    // scenarios
    // ****
    // descriptor beats auto tag
    task automatic tag_source();
        tx(1'b1, 16'ha00b, 1'b1, 3'h0, 4'h0);
        check({tx_tag_en_o, tx_tag_o}, 17'h1a00b);
        check({tx_fcs_recalc_o, tx_tag_offset_o}, 9'h10c);
        tx(1'b0, 16'h5a5a, 1'b1, 3'h0, 4'h0);
        check({tx_tag_en_o, tx_tag_o}, 17'h16c21);
        tx(1'b0, 16'h5a5a, 1'b0, 3'h0, 4'h0);
        check({tx_tag_en_o, tx_fcs_recalc_o}, 2'h0);
        // enable low: a waiting tagged request must not start or latch
        @(posedge clk_i);
        {ce_i, tx_req_i, desc_tag_insert_req_i} <= 3'h3;
        repeat (2) @(posedge clk_i);
        #1;
        check({tx_go_o, tx_start_o, tx_tag_en_o}, 3'h0);
        @(posedge clk_i);
        {ce_i, tx_req_i, desc_tag_insert_req_i} <= 3'h4;
    endtask
    // host clears unwanted requests
    // entries: v6 enable, v4, v6, tcp, udp, requests udp tcp ip
    task automatic csum_table();
        logic [7:0] t [6] = '{8'h57, 8'hb7, 8'h37, 8'hab, 8'h87, 8'h4d};
        logic sel;
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_i);
            v6_checksum_enable_i <= t[i][7];
            tx(1'b0, 16'h0000, 1'b0, t[i][2:0], t[i][6:3]);
            sel = t[i][6] | (t[i][5] & t[i][7]);
            check(tx_csum_do_o, {t[i][2] & t[i][3] & sel, t[i][1] & t[i][4] & sel,
                                 t[i][0] & t[i][6]});
        end
    endtask
    task automatic rx_frames();
        logic [18:0] t [4] = '{19'h605f2, 19'h505f3, 19'h205ee, 19'h105ef};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            auto_untag_enable_i <= t[i][17];
            rx(t[i][18], 16'hb120 + 16'(i), t[i][15:0], 1'b0, 1'b0, 16'h0000, 4'h0);
            check({rx_len_err_o, rx_deliver_o}, {t[i][16], !t[i][16]});
            check(rx_status_tagged_o, t[i][18]);
            if (t[i][18]) begin
                check({rx_strip_o, tag_control_field_o},
                      {t[i][17], 16'hb120 + 16'(i)});
            end
        end
        @(posedge clk_i);
        {v6_checksum_enable_i, rx_csum_enable_i} <= 4'hb; // verify ip and tcp only
        rx(1'b0, 16'h0000, 16'h0040, 1'b0, 1'b0, 16'h0000, 4'b0110);
        check(rx_csum_chk_o, 3'b010);
        rx(1'b0, 16'h0000, 16'h0040, 1'b0, 1'b0, 16'h0000, 4'b1001);
        check(rx_csum_chk_o, 3'b001);
    endtask
    task automatic id_filter();
        logic [11:0] ids [4] = '{12'h123, 12'h124, 12'h045, 12'h046};
        logic [5:0] h;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            {tag_id_exact_filter_i, tag_id_hash_filter_i} <= (i < 2) ? 2'h2 : 2'h1;
            {tag_id_match_i, tag_id_hash_table_i} <= {12'h123, 64'h10};
            rx(1'b1, {4'h0, ids[i]}, 16'h0040, 1'b0, 1'b0, 16'h0000, 4'h0);
            h = ids[i][5:0] ^ ids[i][11:6];
            check(rx_deliver_o, (i < 2) ? (ids[i] == 12'h123) : (h == 6'h04));
        end
        rx(1'b0, 16'h0045, 16'h0040, 1'b0, 1'b0, 16'h0000, 4'h0);
        check(rx_deliver_o, 1'b0);
        @(posedge clk_i);
        tag_id_hash_filter_i <= 1'b0;
        rx(1'b0, 16'h0045, 16'h0040, 1'b0, 1'b0, 16'h0000, 4'h0);
        check(rx_deliver_o, 1'b1);
    endtask
    task automatic prio_irq();
        @(posedge clk_i);
        rx_priority_threshold_i <= 3'h5;
        rx(1'b1, 16'h8001, 16'h0040, 1'b0, 1'b0, 16'h0000, 4'h0);
        check(rx_priority_irq_flag_o, 1'b0);
        rx(1'b1, 16'ha001, 16'h0040, 1'b0, 1'b0, 16'h0000, 4'h0);
        check(rx_priority_irq_flag_o, 1'b1);
        // acknowledge held across a new hit: the set must win
        @(posedge clk_i);
        irq_flags_ack_i <= 1'b1;
        rx(1'b1, 16'he001, 16'h0040, 1'b0, 1'b0, 16'h0000, 4'h0);
        check(rx_priority_irq_flag_o, 1'b1);
        @(posedge clk_i);
        irq_flags_ack_i <= 1'b0;
        rx(1'b0, 16'he001, 16'h0040, 1'b0, 1'b0, 16'h0000, 4'h0);
        check(rx_priority_irq_flag_o, 1'b0);
    endtask
    task automatic pause_obey();
        @(posedge clk_i);
        {flow_enable_i, tx_req_i} <= 2'h3;
        rx(1'b0, 16'h0000, 16'h0040, 1'b1, 1'b1, 16'h0001, 4'h0);
        for (int i = 0; i < 7; i++) begin
            check({paused_o, tx_go_o}, (i < 6) ? 2'h2 : 2'h1);
            @(posedge clk_i);
            #1;
        end
        // long enough that a narrowed timer would already have run out
        rx(1'b0, 16'h0000, 16'h0040, 1'b1, 1'b1, 16'hffff, 4'h0);
        repeat (1600) @(posedge clk_i);
        #1;
        check(paused_o, 1'b1);
        rx(1'b0, 16'h0000, 16'h0040, 1'b1, 1'b1, 16'h0000, 4'h0);
        check(paused_o, 1'b0);
        @(posedge clk_i);
        {flow_enable_i, tx_req_i} <= 2'h0;
        rx(1'b0, 16'h0000, 16'h0040, 1'b1, 1'b1, 16'h0005, 4'h0);
        check(paused_o, 1'b0);
    endtask
    task automatic auto_pause();
        int c;
        @(posedge clk_i);
        {flow_enable_i, flow_symmetric_i, rx_fifo_level_i} <= {2'h3, 16'h0200};
        count_sends(3, c);
        check(c, 0);
        rx_fifo_level_i <= 16'h0400;
        count_sends(4, c);
        check(c, 1);
        rx_fifo_level_i <= 16'h0300;
        rx(1'b0, 16'h0000, 16'h0040, 1'b0, 1'b0, 16'h0000, 4'h0);
        count_sends(3, c);
        check(c, 1);
        rx(1'b0, 16'h0000, 16'h0040, 1'b1, 1'b0, 16'h0000, 4'h0);
        count_sends(3, c);
        check(c, 0);
        rx_fifo_level_i <= 16'h0100;
        count_sends(2, c);
        rx(1'b0, 16'h0000, 16'h0040, 1'b0, 1'b0, 16'h0000, 4'h0);
        count_sends(3, c);
        check(c, 0);
        {flow_symmetric_i, rx_fifo_level_i} <= {1'b0, 16'h0500};
        count_sends(4, c);
        check(c, 0);
    endtask

    // ****
    // clock, watchdog and main sequence
    // ****
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // the sequence needs about two thousand cycles
    initial begin
        repeat (6000) @(posedge clk_i);
        bad_count++;
        results();
    end
    // on level kept low, leaving headroom
    initial begin
        {ce_i, auto_tag_enable_i, auto_untag_enable_i, v6_checksum_enable_i} = 4'h8;
        {tag_id_exact_filter_i, tag_id_hash_filter_i, flow_enable_i, flow_symmetric_i} = 4'h0;
        {tx_req_i, desc_tag_insert_req_i, irq_flags_ack_i, tx_l34} = 7'h00;
        {rx_priority_threshold_i, rx_csum_enable_i, tx_frame_control_word_i} = 9'h1f8;
        {tag_id_match_i, tag_id_hash_table_i} = {12'h000, 64'h0};
        {default_tag_value_i, desc_tag_i, rx_fifo_level_i} = {16'h6c21, 16'h0000, 16'h0000};
        {pause_on_level_i, pause_off_level_i} = {16'h0400, 16'h0100};
        sys_rst_i = 1'b1;
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        #1;
        check({tx_start_o, rx_valid_o, paused_o, pause_send_o, tx_tag_offset_o},
              12'h00c);
        tag_source();
        csum_table();
        rx_frames();
        id_filter();
        prio_irq();
        pause_obey();
        auto_pause();
        results();
    end
endmodule
